/* File: verilog/pwm_ctl_pkg.sv */
// Package with register map, field layout and carrier types of the PWM global control block.
// Function
// - Prescale code 00/01/10/11 divides bus clock by 1/2/4/8 for the timer counter.
// - A new prescale code takes effect at the start of the next period, or in the next cycle while the period is zero.
// - Halt-in-wait clear: wait mode leaves the controller and pins running.
// - Halt-in-wait set: wait mode stops the module clock and releases all pins; the code freezes prescaler and counter, the clock runs on.
// - Resolution bit clear selects 11-bit resolution with word duty access.
// - Resolution bit set selects 7-bit resolution with byte duty access.
// - Bit 2 of the first control register enables dither.
// - The overflow flag is set on every timer counter overflow.
// - Writing one clears the overflow flag, zero leaves it; reset clears it.
// - Recirculation bit affects only full and dual full H-bridge channels.
// - Half H-bridge mode always uses an active-low PWM level.
// - Recirculation set inverts the sign bit effect in full bridge modes.
// - Recirculation zero: PWM active level low, static output high.
// - Recirculation one: PWM active level high, static output low.
// - With overflow interrupt enabled, interrupt is raised while the flag is set.
// - A period lasts the period count of timer clocks; overflow ends it.
// - With dither, period bit zero reads zero and period is twice bits 10:1.
package pwm_ctl_pkg;

  // ==========================================================================
  // Register map: word index of the first three registers; their byte address is four times the index.
  localparam int IDX_GLOBAL_CTL = 0;
  localparam int IDX_LOW_SIDE_RECIRCULATION_CTL = 1;
  localparam int IDX_PERIOD     = 2;
  localparam logic [7:0] ADDR_GLOBAL_CTL = 8'(4 * IDX_GLOBAL_CTL);
  localparam logic [7:0] ADDR_LOW_SIDE_RECIRCULATION_CTL = 8'(4 * IDX_LOW_SIDE_RECIRCULATION_CTL);
  localparam logic [7:0] ADDR_PERIOD     = 8'(4 * IDX_PERIOD);
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int PRE_LSB   = 5;
  localparam int PRE_MSB   = 6;
  localparam int HALT_BIT  = 4;
  localparam int FAST_BIT  = 3;
  localparam int DITHER_ENABLE_BIT  = 2;
  localparam int OVF_BIT   = 0;
  localparam int LOW_SIDE_RECIRCULATION_BIT = 7;
  localparam int OVFIE_BIT = 0;

  localparam logic [7:0] GLOBAL_WMASK = 8'h7C;
  localparam logic [7:0] LOW_SIDE_RECIRCULATION_WMASK = 8'h81;
  localparam logic [10:0] PERIOD_MASK_DITHER_ENABLE = 11'h7FE;
  localparam logic [10:0] PERIOD_RESET = 11'h000;
  localparam logic [7:0]  CTL_RESET    = 8'h00;

  // ==========================================================================
  // Prescale codes.
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV2 = 2'h1;
  localparam logic [1:0] PRE_DIV4 = 2'h2;
  localparam logic [1:0] PRE_DIV8 = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // Output modes of one channel.
  localparam logic [1:0] OM_HALF_M = 2'h0;
  localparam logic [1:0] OM_HALF_P = 2'h1;
  localparam logic [1:0] OM_FULL   = 2'h2;
  localparam logic [1:0] OM_DUAL   = 2'h3;

  // Settings handed to the waveform generator.
  typedef struct packed {
    logic       fast_mode;
    logic       dither_enable;
    logic       low_side_recirculation;
    logic       pins_released;
  } gen_cfg_s;

endpackage

/* File: verilog/motor_pwm_global_control.sv */
// Global control of the motor PWM: prescaler, period counter, overflow flag and bus slave.
`timescale 1ns/1ps
module motor_pwm_global_control #(
  parameter int NCH = 8                          // Number of PWM channels.
) (
  input  wire logic              clk,            // Bus clock, 250 MHz.
  input  wire logic              rstn,           // Asynchronous reset, active low.
  input  wire logic              psel,           // APB select.
  input  wire logic              penable,        // APB access phase.
  input  wire logic              pwrite,         // APB direction.
  input  wire logic [7:0]        paddr,          // APB byte address.
  input  wire logic [31:0]       pwdata,         // APB write data.
  input  wire logic [3:0]        pstrb,          // APB byte strobes.
  output logic      [31:0]       prdata,         // APB read data.
  output logic                   pready,         // APB ready.
  output logic                   pslverr,        // APB error, unmapped address.
  input  wire logic              wait_mode,      // System wait mode request, async pin.
  input  wire logic [2*NCH-1:0]  chan_mode,      // Output mode per channel, same clock.
  input  wire logic [NCH-1:0]    chan_sign,      // Sign bit per channel, same clock.
  output logic                   tc_tick,        // Timer counter clock enable pulse.
  output logic                   tc_overflow,    // One-cycle pulse at end of period.
  output pwm_ctl_pkg::gen_cfg_s  gen_cfg,        // Settings to the waveform generator.
  output logic [NCH-1:0]         pwm_active_lvl, // Active PWM level per channel.
  output logic [NCH-1:0]         sign_eff,       // Effective sign per channel.
  output logic                   irq             // Level interrupt.
);

  // ==========================================================================
  // Registers.
  logic [1:0]  pre_sel_ff;
  logic [1:0]  pre_act_ff;
  logic        halt_ff;
  logic        fast_ff;
  logic        dither_enable_ff;
  logic        ovf_ff;
  logic        low_side_recirculation_ff;
  logic        ovfie_ff;
  logic [10:0] period_ff;
  logic [10:0] tc_cnt_ff;
  logic [2:0]  div_ff;
  logic        wait_s1_ff;
  logic        wait_s2_ff;
  logic        ovf_mask_ff;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        stopped;
  logic        tick;
  logic [2:0]  div_mask;
  logic [10:0] per_eff;
  logic        period_end;
  logic [31:0] nxt_rdata;
  logic [NCH-1:0] nxt_pwm_active_lvl;
  logic [NCH-1:0] nxt_sign_eff;

  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == pwm_ctl_pkg::ADDR_GLOBAL_CTL) |
                   (paddr == pwm_ctl_pkg::ADDR_LOW_SIDE_RECIRCULATION_CTL) |
                   (paddr == pwm_ctl_pkg::ADDR_PERIOD) |
                   (paddr == pwm_ctl_pkg::ADDR_IRQ_STATUS) |
                   (paddr == pwm_ctl_pkg::ADDR_IRQ_MASK);

  // ==========================================================================
  // Wait mode pin synchroniser.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_s1_ff <= 1'b0;
      wait_s2_ff <= 1'b0;
    end else begin
      wait_s1_ff <= wait_mode;
      wait_s2_ff <= wait_s1_ff;
    end
  end

  // Halting freezes the counter in place rather than gating the clock, which keeps timing clean.
  assign stopped = wait_s2_ff & halt_ff;

  // ==========================================================================
  // Control registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_sel_ff <= pwm_ctl_pkg::PRE_DIV1;
      halt_ff    <= 1'b0;
      fast_ff    <= 1'b0;
      dither_enable_ff    <= 1'b0;
      low_side_recirculation_ff  <= 1'b0;
      ovfie_ff   <= 1'b0;
      period_ff  <= pwm_ctl_pkg::PERIOD_RESET;
    end else if (wr_en) begin
      if (pstrb[0] && paddr == pwm_ctl_pkg::ADDR_GLOBAL_CTL) begin
        pre_sel_ff <= pwdata[pwm_ctl_pkg::PRE_MSB:pwm_ctl_pkg::PRE_LSB];
        halt_ff    <= pwdata[pwm_ctl_pkg::HALT_BIT];
        fast_ff    <= pwdata[pwm_ctl_pkg::FAST_BIT];
        dither_enable_ff    <= pwdata[pwm_ctl_pkg::DITHER_ENABLE_BIT];
      end
      if (pstrb[0] && paddr == pwm_ctl_pkg::ADDR_LOW_SIDE_RECIRCULATION_CTL) begin
        low_side_recirculation_ff <= pwdata[pwm_ctl_pkg::LOW_SIDE_RECIRCULATION_BIT];
        ovfie_ff  <= pwdata[pwm_ctl_pkg::OVFIE_BIT];
      end
      // Each byte lane of the period word lands on its own, so a full-word write sets all bits.
      if (pstrb[0] && paddr == pwm_ctl_pkg::ADDR_PERIOD) begin
        period_ff[7:0] <= pwdata[7:0];
      end
      if (pstrb[1] && paddr == pwm_ctl_pkg::ADDR_PERIOD) begin
        period_ff[10:8] <= pwdata[10:8];
      end
    end
  end

  // ==========================================================================
  // Prescaler; the active code is reloaded at a period boundary and in every cycle while the period is zero.
  always_comb begin
    unique case (pre_act_ff)
      pwm_ctl_pkg::PRE_DIV1: div_mask = 3'h0;
      pwm_ctl_pkg::PRE_DIV2: div_mask = pwm_ctl_pkg::DIV2_MASK;
      pwm_ctl_pkg::PRE_DIV4: div_mask = pwm_ctl_pkg::DIV4_MASK;
      pwm_ctl_pkg::PRE_DIV8: div_mask = pwm_ctl_pkg::DIV8_MASK;
    endcase
  end

  assign tick = ~stopped & ((div_ff & div_mask) == div_mask);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 3'h0;
    end else if (!stopped) begin
      div_ff <= (tick) ? 3'h0 : div_ff + 3'h1;
    end
  end

  // ==========================================================================
  // Period counter.
  assign per_eff = dither_enable_ff ? (period_ff & pwm_ctl_pkg::PERIOD_MASK_DITHER_ENABLE) : period_ff;
  assign period_end = tick & (per_eff != 11'h000) & (tc_cnt_ff >= per_eff - 11'h001);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tc_cnt_ff  <= 11'h000;
      pre_act_ff <= pwm_ctl_pkg::PRE_DIV1;
    end else if (period_end || per_eff == 11'h000) begin
      tc_cnt_ff  <= 11'h000;
      pre_act_ff <= pre_sel_ff;
    end else if (tick) begin
      tc_cnt_ff <= tc_cnt_ff + 11'h001;
    end
  end

  // ==========================================================================
  // Overflow flag; a set in the clearing cycle wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_ff <= 1'b0;
    end else if (period_end) begin
      ovf_ff <= 1'b1;
    end else if (wr_en && pstrb[0] && pwdata[pwm_ctl_pkg::OVF_BIT] &&
                 (paddr == pwm_ctl_pkg::ADDR_GLOBAL_CTL ||
                  paddr == pwm_ctl_pkg::ADDR_IRQ_STATUS)) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_mask_ff <= 1'b0;
    end else if (wr_en && pstrb[0] && paddr == pwm_ctl_pkg::ADDR_IRQ_MASK) begin
      ovf_mask_ff <= pwdata[pwm_ctl_pkg::OVF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= ovf_ff & (ovfie_ff | ovf_mask_ff);
    end
  end

  // ==========================================================================
  // Timing and configuration outputs to the waveform generator.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tc_tick     <= 1'b0;
      tc_overflow <= 1'b0;
      gen_cfg     <= '0;
    end else begin
      tc_tick                        <= tick;
      tc_overflow                    <= period_end;
      gen_cfg.fast_mode              <= fast_ff;
      gen_cfg.dither_enable          <= dither_enable_ff;
      gen_cfg.low_side_recirculation <= low_side_recirculation_ff;
      gen_cfg.pins_released          <= stopped;
    end
  end

  // Recirculation must only change while no channel is in a full bridge mode.
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    logic full_mode;
    assign full_mode = (chan_mode[2*g +: 2] == pwm_ctl_pkg::OM_FULL) |
                       (chan_mode[2*g +: 2] == pwm_ctl_pkg::OM_DUAL);
    assign nxt_pwm_active_lvl[g] = full_mode ? low_side_recirculation_ff : 1'b0;
    assign nxt_sign_eff[g]       = chan_sign[g] ^ (full_mode & low_side_recirculation_ff);
  end

  // One register process for all channels keeps each output vector with a single writer.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_active_lvl <= '0;
      sign_eff       <= '0;
    end else begin
      pwm_active_lvl <= nxt_pwm_active_lvl;
      sign_eff       <= nxt_sign_eff;
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, data registered in the setup cycle.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (paddr == pwm_ctl_pkg::ADDR_GLOBAL_CTL) begin
      nxt_rdata[pwm_ctl_pkg::PRE_MSB:pwm_ctl_pkg::PRE_LSB] = pre_sel_ff;
      nxt_rdata[pwm_ctl_pkg::HALT_BIT] = halt_ff;
      nxt_rdata[pwm_ctl_pkg::FAST_BIT] = fast_ff;
      nxt_rdata[pwm_ctl_pkg::DITHER_ENABLE_BIT] = dither_enable_ff;
      nxt_rdata[pwm_ctl_pkg::OVF_BIT]  = ovf_ff;
    end else if (paddr == pwm_ctl_pkg::ADDR_LOW_SIDE_RECIRCULATION_CTL) begin
      nxt_rdata[pwm_ctl_pkg::LOW_SIDE_RECIRCULATION_BIT] = low_side_recirculation_ff;
      nxt_rdata[pwm_ctl_pkg::OVFIE_BIT]  = ovfie_ff;
    end else if (paddr == pwm_ctl_pkg::ADDR_PERIOD) begin
      nxt_rdata[10:0] = per_eff;
    end else if (paddr == pwm_ctl_pkg::ADDR_IRQ_STATUS) begin
      nxt_rdata[pwm_ctl_pkg::OVF_BIT] = ovf_ff;
    end else if (paddr == pwm_ctl_pkg::ADDR_IRQ_MASK) begin
      nxt_rdata[pwm_ctl_pkg::OVF_BIT] = ovf_mask_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        prdata <= nxt_rdata;
      end
    end
  end

endmodule // motor_pwm_global_control

/* File: verification/pwm_ctl_chk.sv */
// Checker of bus timing, channel polarity, pin release and flag clearing.
`timescale 1ns/1ps
module pwm_ctl_chk #(
  parameter int NCH = 8 // Channels.
) (
  input wire logic                  clk,            // Clock.
  input wire logic                  rstn,           // Reset.
  input wire logic                  psel,           // Select.
  input wire logic                  penable,        // Access.
  input wire logic                  pwrite,         // Write.
  input wire logic [7:0]            paddr,          // Address.
  input wire logic [31:0]           pwdata,         // Data in.
  input wire logic [3:0]            pstrb,          // Strobes.
  input wire logic [31:0]           prdata,         // Data out.
  input wire logic                  pready,         // Ready.
  input wire logic                  pslverr,        // Error.
  input wire logic                  wait_mode,      // Wait.
  input wire logic [2*NCH-1:0]      chan_mode,      // Modes.
  input wire logic [NCH-1:0]        chan_sign,      // Signs.
  input wire logic                  tc_tick,        // Tick.
  input wire logic                  tc_overflow,    // Overflow.
  input wire pwm_ctl_pkg::gen_cfg_s gen_cfg,        // Settings.
  input wire logic [NCH-1:0]        pwm_active_lvl, // Levels.
  input wire logic [NCH-1:0]        sign_eff,       // Signs out.
  input wire logic                  irq             // Interrupt.
);
  // ==========
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_ready_setup:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ovf_on_tick:
    assert property (tc_overflow |-> tc_tick) else $error("overflow without tick");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_lvl_half:
    assert property (!$past(chan_mode[1]) |-> !pwm_active_lvl[0]) else $error("half level");
  a_lvl_full:
    assert property ($past(chan_mode[1]) |-> pwm_active_lvl[0] ==
      gen_cfg.low_side_recirculation) else $error("full level");
  a_sign_half:
    assert property (!$past(chan_mode[1]) |-> sign_eff[0] == $past(chan_sign[0]))
      else $error("half sign");
  a_sign_full:
    assert property ($past(chan_mode[1]) |-> sign_eff[0] ==
      ($past(chan_sign[0]) ^ gen_cfg.low_side_recirculation)) else $error("full sign");
  a_release_frozen:
    assert property (gen_cfg.pins_released && $past(gen_cfg.pins_released) |->
      !tc_overflow) else $error("overflow while halted");
  a_irq_clear:
    assert property (psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0]
      && pwdata[0] && !tc_overflow ##1 !tc_overflow |=> !irq) else $error("irq stays");
endmodule // pwm_ctl_chk

/* File: verification/coil_model.sv */
// Coil pin model: follows the driven level and floats when released.
`timescale 1ns/1ps
module coil_model (
  input  wire logic       clk,  // Clock.
  input  wire logic       rel,  // Pins released.
  input  wire logic [7:0] lvl,  // Driven level.
  output logic      [7:0] coil  // Seen level.
);
  // No pull on a coil, so a released pin toggles rather than holding its last value.
  always_ff @(posedge clk) begin
    coil <= rel ? ~coil : lvl;
  end
endmodule // coil_model

/* File: verification/tb.sv */
// Self-checking bench of the PWM global control block.
`timescale 1ns/1ps
module tb;
  localparam int NCH = 8;
  localparam logic [7:0] A_CTL = pwm_ctl_pkg::ADDR_GLOBAL_CTL;
  localparam logic [7:0] A_REC = pwm_ctl_pkg::ADDR_LOW_SIDE_RECIRCULATION_CTL;
  localparam logic [7:0] A_PER = pwm_ctl_pkg::ADDR_PERIOD;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, wait_mode, tc_tick, tc_overflow, irq;
  logic [7:0]            paddr, pwm_active_lvl, sign_eff, coil, chan_sign;
  logic [31:0]           pwdata, prdata;
  logic [3:0]            pstrb;
  logic [15:0]           chan_mode, s;
  pwm_ctl_pkg::gen_cfg_s gen_cfg;
  logic [32:0]           q[$];
  int                    n_errors, n_checks, cyc, n, t0;
  motor_pwm_global_control #(.NCH(NCH)) dut (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .wait_mode, .chan_mode, .chan_sign, .tc_tick, .tc_overflow, .gen_cfg,
    .pwm_active_lvl, .sign_eff, .irq);
  coil_model u_coil (.clk, .rel(gen_cfg.pins_released), .lvl(pwm_active_lvl), .coil);
  always #2 clk = ~clk;
  // ==========
  // Tasks
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The extra edge after release keeps a following call from re-driving psel in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic gap(output int g);
    @(posedge clk iff tc_overflow === 1'b1);
    t0 = cyc;
    @(posedge clk iff tc_overflow === 1'b1);
    g = cyc - t0;
  endtask
  task automatic irq_is(input logic [32:0] e);
    repeat (2) @(posedge clk);
    cmp(33'(irq), e);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if ((psel && penable && pready && !pwrite) === 1'b1) begin
      cmp({pslverr, prdata}, q.pop_front());
    end
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  // ==========
  // Sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, wait_mode} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    chan_mode = 16'h0;
    chan_sign = 8'h00;
    s = 16'h0007;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(A_CTL, 33'h0);
    rd(A_REC, 33'h0);
    rd(8'h14, 33'h100000000);
    apb(1'b1, A_PER, 32'h7FF);
    rd(A_PER, 33'h7FF);
    apb(1'b1, A_CTL, 32'hFFFFFFFF);
    rd(A_CTL, 33'h7C);
    cmp(33'(gen_cfg), 33'hC);
    rd(A_PER, 33'h7FE);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_PER, 32'h0);
      apb(1'b1, A_CTL, 32'(c) << pwm_ctl_pkg::PRE_LSB);
      apb(1'b1, A_PER, 32'h4);
      gap(n);
      cmp(33'(n), 33'(4 << c));
    end
    cmp(33'(gen_cfg), 33'h0);
    @(posedge clk iff tc_overflow === 1'b1);
    t0 = cyc;
    apb(1'b1, A_CTL, 32'h0);
    @(posedge clk iff tc_overflow === 1'b1);
    cmp(33'(cyc - t0), 33'd32);
    gap(n);
    cmp(33'(n), 33'd4);
    apb(1'b1, A_CTL, 32'h1 << pwm_ctl_pkg::DITHER_ENABLE_BIT);
    apb(1'b1, A_PER, 32'h5);
    rd(A_PER, 33'h4);
    gap(n);
    cmp(33'(n), 33'd4);
    $display("test timing done");
    apb(1'b1, A_PER, 32'h0);
    repeat (20) @(posedge clk);
    apb(1'b1, A_CTL, 32'h0);
    rd(A_CTL, 33'h1);
    rd(pwm_ctl_pkg::ADDR_IRQ_STATUS, 33'h1);
    irq_is(33'h0);
    apb(1'b1, pwm_ctl_pkg::ADDR_IRQ_MASK, 32'h1);
    irq_is(33'h1);
    apb(1'b1, pwm_ctl_pkg::ADDR_IRQ_MASK, 32'h0);
    irq_is(33'h0);
    apb(1'b1, A_REC, 32'h1);
    irq_is(33'h1);
    apb(1'b1, A_CTL, 32'h1);
    irq_is(33'h0);
    rd(A_CTL, 33'h0);
    $display("test flag done");
    for (int r = 1; r >= 0; r--) begin
      chan_mode <= 16'h0;
      chan_sign <= 8'h00;
      apb(1'b1, A_REC, 32'(r) << pwm_ctl_pkg::LOW_SIDE_RECIRCULATION_BIT);
      chan_mode <= 16'hFFFF;
      repeat (2) @(posedge clk);
      cmp(33'(pwm_active_lvl), 33'({8{r[0]}}));
      cmp(33'(sign_eff), 33'({8{r[0]}}));
      for (int i = 0; i < 64; i++) begin
        s = lfsr(s);
        chan_mode <= {s[7:0], s[15:8]};
        chan_sign <= s[11:4];
        @(posedge clk);
      end
    end
    chan_mode <= 16'h0;
    $display("test recirculation done");
    apb(1'b1, A_PER, 32'h4);
    wait_mode <= 1'b1;
    gap(n);
    cmp(33'(n), 33'd4);
    cmp(33'(coil), 33'(pwm_active_lvl));
    apb(1'b1, A_CTL, 32'h1 << pwm_ctl_pkg::HALT_BIT);
    repeat (4) @(posedge clk);
    cmp(33'(gen_cfg.pins_released), 33'h1);
    n = int'(coil);
    @(posedge clk);
    cmp(33'(coil ^ n[7:0]), 33'hFF);
    repeat (40) @(posedge clk);
    wait_mode <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(33'(gen_cfg.pins_released), 33'h0);
    $display("test wait done");
    test_done();
  end
endmodule // tb
bind motor_pwm_global_control pwm_ctl_chk #(.NCH(NCH)) u_chk (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .wait_mode, .chan_mode, .chan_sign, .tc_tick, .tc_overflow, .gen_cfg,
  .pwm_active_lvl, .sign_eff, .irq);
